// ---- logic/host_pkt_rx.sv ----
// Host packet deframer: sync, header, header check, body, body check
module host_pkt_rx
  import stc_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Byte stream from host
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  // Decoded packet
  output logic            pkt_valid,
  output host_pkt_s       pkt,
  output logic            pkt_err
);
  typedef enum logic [2:0] {P_SYNC, P_HDR, P_HCRC, P_BODY, P_DCRC} pst_e;
  pst_e        st_r;
  logic [15:0] cnt_r;
  logic [7:0]  crc_r;
  logic [7:0]  crc_nxt;
  logic [16:0] body_len;

  assign crc_nxt  = crc8_step(crc_r, rx_data);
  assign body_len = {1'b0, pkt.dlen} + {9'h000, pkt.olen};

  // ==========================================================================
  // Framing; a bad check byte drops the packet and hunts for sync again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= P_SYNC;
      cnt_r     <= 16'h0000;
      crc_r     <= 8'h00;
      pkt       <= '0;
      pkt_valid <= 1'b0;
      pkt_err   <= 1'b0;
    end else begin
      pkt_valid <= 1'b0;
      pkt_err   <= 1'b0;
      if (rx_valid) begin
        unique case (st_r)
          P_SYNC: if (rx_data == SYNC_BYTE) begin
            st_r  <= P_HDR;
            cnt_r <= 16'h0000;
            crc_r <= 8'h00;
          end
          P_HDR: begin
            crc_r <= crc_nxt;
            cnt_r <= cnt_r + 16'h0001;
            unique case (cnt_r[1:0])
              2'd0: pkt.dlen[15:8] <= rx_data;
              2'd1: pkt.dlen[7:0]  <= rx_data;
              2'd2: pkt.olen       <= rx_data;
              2'd3: pkt.ptype      <= rx_data;
            endcase
            if (cnt_r[1:0] == 2'd3) begin
              st_r <= P_HCRC;
            end
          end
          P_HCRC: begin
            cnt_r <= 16'h0000;
            crc_r <= 8'h00;
            if (rx_data != crc_r) begin
              st_r    <= P_SYNC;
              pkt_err <= 1'b1;
            end else begin
              st_r <= (body_len == 17'h00000) ? P_DCRC : P_BODY;
            end
          end
          P_BODY: begin
            crc_r <= crc_nxt;
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r < 16'h0008) begin
              pkt.body[cnt_r[2:0]] <= rx_data;
            end
            if ({1'b0, cnt_r} == body_len - 17'h00001) begin
              st_r <= P_DCRC;
            end
          end
          P_DCRC: begin
            st_r      <= P_SYNC;
            pkt_valid <= (rx_data == crc_r);
            pkt_err   <= (rx_data != crc_r);
          end
        endcase
      end
    end
  end
endmodule

// ---- logic/link_table_mem.sv ----
// Inbound secure link table storage with registered read data
module link_table_mem
  import stc_pkg::*;
(
  // Clock
  input  wire logic        pclk,
  // Read port
  input  wire logic [4:0]  rd_addr,
  output link_entry_s      rd_data,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  link_entry_s      wr_data
);
  link_entry_s mem [TABLE_DEPTH];

  // ==========================================================================
  // Storage; contents are undefined until written, validity lives outside
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ---- logic/secure_teach_in_control.sv ----
// Secure teach-in controller: host commands, teach window, link table events
// Overview of operation
// - Keep a 128-bit key per secure link
// - Accept only strictly higher rolling counter values
// - Both ends hold identical security parameters
// - Unlinked telegrams pass through without security
// - Linked senders get a rolling counter check here
// - Command 0x20 sends teach telegram, outbound only
// - Command 0x17 opens window; zero means 60000 ms
// - Channel byte: absolute, previous or next
// - Window open: valid teach telegram creates entry
// - Successful teach-in reports secure-link event
// - Window end sends event 0x09 packet
// - At most 32 entries; overflow reports 00
// - Outside window, matching telegram resyncs counter
// - Outside window, teach telegrams of unknown senders are discarded
// - Successful resync reports secure-link event
module secure_teach_in_control
  import stc_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Host byte link
  input  wire logic        host_rx_valid,
  input  wire logic [7:0]  host_rx_data,
  output logic             host_tx_valid,
  output logic      [7:0]  host_tx_data,
  input  wire logic        host_tx_ready,
  // Radio receive side
  input  wire logic        tlg_valid,
  input  radio_tlg_s       tlg,
  output logic             tlg_ready,
  output logic             plain_fwd,
  output logic             secure_accept,
  output logic             replay_drop,
  // Radio transmit side and channel
  output logic             send_teach_req,
  output logic      [31:0] send_teach_id,
  output logic      [7:0]  send_teach_info,
  output logic             send_teach_info_en,
  output logic      [7:0]  radio_chan,
  // Status
  output logic             teach_window_active,
  output logic             irq
);
  typedef enum logic [2:0] {M_IDLE, M_READ, M_CMP, M_DECIDE} mst_e;
  typedef enum logic [1:0] {TX_IDLE, TX_WIN, TX_SEC} txk_e;

  // Lowest free slot of the valid map
  function automatic logic [4:0] first_free(input logic [31:0] v);
    logic [4:0] r;
    r = 5'd0;
    for (int i = TABLE_DEPTH - 1; i >= 0; i--) begin
      if (!v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Event packet byte at a position, given the running check value
  function automatic logic [7:0] evt_byte(input txk_e k, input logic [3:0] i,
                                          input logic [7:0] crc,
                                          input logic [7:0] cause,
                                          input logic [31:0] id);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      4'd0:  b = SYNC_BYTE;
      4'd2:  b = (k == TX_WIN) ? WIN_EVT_DLEN : SEC_EVT_DLEN;
      4'd4:  b = PT_EVENT;
      4'd5:  b = crc;
      4'd6:  b = (k == TX_WIN) ? EVT_WIN_CLOSED : EVT_SECURE_LINK;
      4'd7:  b = (k == TX_WIN) ? crc : cause;
      4'd8:  b = id[31:24];
      4'd9:  b = id[23:16];
      4'd10: b = id[15:8];
      4'd11: b = id[7:0];
      4'd12: b = crc;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ==========================================================================
  // Signals
  host_pkt_s   pkt;
  logic        pkt_valid;
  logic        pkt_err;
  link_entry_s rd_entry;
  logic        mem_we;
  logic [4:0]  mem_waddr;
  link_entry_s mem_wdata;
  mst_e        mst_r;
  radio_tlg_s  tlg_r;
  logic [4:0]  idx_r;
  logic        found_r;
  logic [4:0]  hit_r;
  link_entry_s hit_ent_r;
  logic [31:0] vmap_r;
  logic [6:0]  stat_r;
  logic [6:0]  mask_r;
  logic [6:0]  stat_set;
  logic [31:0] out_id_r;
  logic        out_valid_r;
  logic        win_r;
  logic [31:0] ms_left_r;
  logic [31:0] pre_r;
  logic        win_evt_r;
  logic        sec_evt_r;
  logic [7:0]  sec_cause_r;
  logic [31:0] sec_id_r;
  txk_e        txk_r;
  logic [3:0]  tx_idx_r;
  logic [7:0]  tx_crc_r;

  // ==========================================================================
  // Submodules
  host_pkt_rx u_rx (
    .pclk      (pclk),
    .presetn   (presetn),
    .rx_valid  (host_rx_valid),
    .rx_data   (host_rx_data),
    .pkt_valid (pkt_valid),
    .pkt       (pkt),
    .pkt_err   (pkt_err)
  );

  link_table_mem u_tab (
    .pclk    (pclk),
    .rd_addr (idx_r),
    .rd_data (rd_entry),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata)
  );

  // ==========================================================================
  // Command decode; short or foreign packets are simply not acted on
  wire is_cmd     = pkt_valid && (pkt.ptype == PT_COMMON);
  wire cmd_send   = is_cmd && (pkt.body[0] == CMD_SEND_TEACH)
                    && (pkt.dlen >= SEND_TEACH_DLEN);
  wire cmd_win    = is_cmd && (pkt.body[0] == CMD_TEACH_WIN)
                    && (pkt.dlen >= TEACH_WIN_DLEN);
  wire win_start  = cmd_win && (pkt.body[1] == WIN_START);
  wire win_stop   = cmd_win && (pkt.body[1] == WIN_STOP);
  wire chan_given = win_start && (pkt.olen != 8'h00);
  wire [31:0] cmd_id  = {pkt.body[1], pkt.body[2], pkt.body[3], pkt.body[4]};
  wire [31:0] cmd_to  = {pkt.body[2], pkt.body[3], pkt.body[4], pkt.body[5]};
  wire send_ok    = cmd_send && out_valid_r && (cmd_id == out_id_r);
  wire [7:0] chan_sel = pkt.body[6];

  // ==========================================================================
  // Window timing; a ms tick is a free prescaler wrap
  wire ms_tick    = (pre_r == 32'(CYC_PER_MS_P - 1));
  wire win_expire = win_r && ms_tick && (ms_left_r == 32'd1);
  wire win_close  = (win_r && win_stop) || (win_expire && !win_start);

  // ==========================================================================
  // Table decision on the collected lookup result
  wire [4:0] free_slot = first_free(vmap_r);
  wire       tab_full  = &vmap_r;
  wire       fresh     = tlg_r.ent.rolling_counter > hit_ent_r.rolling_counter;
  wire       same_par  = (tlg_r.ent.key == hit_ent_r.key)
                         && (tlg_r.ent.security_level_format == hit_ent_r.security_level_format)
                         && (tlg_r.ent.info == hit_ent_r.info);
  wire dec       = (mst_r == M_DECIDE);
  wire dec_teach = dec && tlg_r.teach;
  wire dec_data  = dec && !tlg_r.teach;
  wire do_learn  = dec_teach && win_r && (found_r || !tab_full);
  wire do_nospc  = dec_teach && win_r && !found_r && tab_full;
  wire do_resync = dec_teach && !win_r && found_r && same_par;
  wire do_accept = dec_data && found_r && fresh;
  wire last_hit  = (rd_entry.id == tlg_r.ent.id) && vmap_r[idx_r];

  assign tlg_ready = (mst_r == M_IDLE);
  assign mem_we    = do_learn || do_resync || do_accept;
  assign mem_waddr = (do_learn && !found_r) ? free_slot : hit_r;
  // Learning stores the telegram whole, keeping the key with it
  assign mem_wdata = do_learn ? tlg_r.ent
                     : '{id: hit_ent_r.id, key: hit_ent_r.key,
                         security_level_format: hit_ent_r.security_level_format, info: hit_ent_r.info,
                         rolling_counter: tlg_r.ent.rolling_counter};

  // ==========================================================================
  // Lookup sequencer: one read and one compare cycle per slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_r     <= M_IDLE;
      tlg_r     <= '0;
      idx_r     <= 5'd0;
      found_r   <= 1'b0;
      hit_r     <= 5'd0;
      hit_ent_r <= '0;
    end else begin
      unique case (mst_r)
        M_IDLE: if (tlg_valid) begin
          tlg_r   <= tlg;
          idx_r   <= 5'd0;
          found_r <= 1'b0;
          mst_r   <= M_READ;
        end
        M_READ: mst_r <= M_CMP;
        M_CMP: begin
          if (last_hit) begin
            found_r   <= 1'b1;
            hit_r     <= idx_r;
            hit_ent_r <= rd_entry;
            mst_r     <= M_DECIDE;
          end else if (idx_r == 5'(TABLE_DEPTH - 1)) begin
            mst_r <= M_DECIDE;
          end else begin
            idx_r <= idx_r + 5'd1;
            mst_r <= M_READ;
          end
        end
        M_DECIDE: mst_r <= M_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Telegram verdicts; unknown senders get no security at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plain_fwd     <= 1'b0;
      secure_accept <= 1'b0;
      replay_drop   <= 1'b0;
      vmap_r        <= 32'h0000_0000;
    end else begin
      plain_fwd     <= dec_data && !found_r;
      secure_accept <= do_accept;
      replay_drop   <= dec_data && found_r && !fresh;
      if (do_learn) begin
        vmap_r[mem_waddr] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Teach window, timeout and channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_r      <= 1'b0;
      ms_left_r  <= 32'h0000_0000;
      pre_r      <= 32'h0000_0000;
      radio_chan <= CHAN_RST;
    end else begin
      pre_r <= ms_tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;
      if (win_start) begin
        win_r     <= 1'b1;
        ms_left_r <= (cmd_to == 32'h0000_0000) ? DEFAULT_TO_MS : cmd_to;
      end else if (win_close) begin
        win_r <= 1'b0;
      end else if (win_r && ms_tick) begin
        ms_left_r <= ms_left_r - 32'h0000_0001;
      end
      if (chan_given) begin
        if (chan_sel <= CH_ABS_MAX) begin
          radio_chan <= chan_sel;
        end else if (chan_sel == CH_PREV) begin
          radio_chan <= radio_chan - 8'h01;
        end else begin
          radio_chan <= radio_chan + 8'h01;
        end
      end
    end
  end

  // ==========================================================================
  // Send teach telegram request, only toward a known outbound peer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_teach_req     <= 1'b0;
      send_teach_id      <= 32'h0000_0000;
      send_teach_info    <= 8'h00;
      send_teach_info_en <= 1'b0;
    end else begin
      send_teach_req <= send_ok;
      if (send_ok) begin
        send_teach_id      <= cmd_id;
        send_teach_info    <= pkt.body[5];
        send_teach_info_en <= (pkt.olen != 8'h00);
      end
    end
  end

  // ==========================================================================
  // Pending events; a new event wins over the launch that clears it
  wire tx_launch = (txk_r == TX_IDLE) && (sec_evt_r || win_evt_r);
  wire sec_set   = do_learn || do_nospc || do_resync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_evt_r   <= 1'b0;
      sec_evt_r   <= 1'b0;
      sec_cause_r <= 8'h00;
      sec_id_r    <= 32'h0000_0000;
    end else begin
      if (win_close) begin
        win_evt_r <= 1'b1;
      end else if (tx_launch && !sec_evt_r) begin
        win_evt_r <= 1'b0;
      end
      if (sec_set) begin
        sec_evt_r   <= 1'b1;
        sec_id_r    <= tlg_r.ent.id;
        sec_cause_r <= do_nospc ? CAUSE_NO_SPACE
                     : (do_resync ? CAUSE_RESYNC : CAUSE_TEACH_OK);
      end else if (tx_launch) begin
        sec_evt_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Event packet sender; check bytes are built on the fly
  wire  tx_take  = (txk_r != TX_IDLE) && host_tx_ready;
  wire  tx_last  = tx_idx_r == ((txk_r == TX_WIN) ? 4'd7 : 4'd12);
  wire [7:0] crc_step = crc8_step(tx_crc_r, host_tx_data);
  wire [7:0] crc_nxt  = (tx_idx_r == 4'd0 || tx_idx_r == 4'd5) ? 8'h00
                        : crc_step;
  wire [3:0] idx_nxt  = tx_idx_r + 4'd1;
  assign host_tx_valid = (txk_r != TX_IDLE);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txk_r        <= TX_IDLE;
      tx_idx_r     <= 4'd0;
      tx_crc_r     <= 8'h00;
      host_tx_data <= 8'h00;
    end else if (tx_launch) begin
      txk_r        <= sec_evt_r ? TX_SEC : TX_WIN;
      tx_idx_r     <= 4'd0;
      tx_crc_r     <= 8'h00;
      host_tx_data <= SYNC_BYTE;
    end else if (tx_take) begin
      tx_idx_r     <= idx_nxt;
      tx_crc_r     <= crc_nxt;
      host_tx_data <= evt_byte(txk_r, idx_nxt, crc_nxt, sec_cause_r,
                               sec_id_r);
      if (tx_last) begin
        txk_r <= TX_IDLE;
      end
    end
  end

  // ==========================================================================
  // APB slave: zero wait states, unmapped addresses answer with an error
  wire apb_acc   = psel && penable;
  wire hit_stat  = paddr == OFS_IRQ_STAT;
  wire hit_mask  = paddr == OFS_IRQ_MASK;
  wire hit_sts   = paddr == OFS_STATUS;
  wire hit_oid   = paddr == OFS_OUT_ID;
  wire hit_octl  = paddr == OFS_OUT_CTRL;
  wire mapped    = hit_stat | hit_mask | hit_sts | hit_oid | hit_octl;
  wire apb_wr    = apb_acc && pwrite && mapped;
  wire [5:0] tab_count = 6'($countones(vmap_r));
  assign pready  = 1'b1;
  assign pslverr = apb_acc && !mapped;
  assign prdata  = hit_stat ? {25'h0, stat_r}
                 : hit_mask ? {25'h0, mask_r}
                 : hit_sts  ? {16'h0, radio_chan, 1'b0, tab_count, win_r}
                 : hit_oid  ? out_id_r
                 : hit_octl ? {31'h0, out_valid_r}
                 : 32'h0000_0000;
  assign teach_window_active = win_r;
  assign irq = |(stat_r & mask_r);

  // Sticky interrupt sources
  always_comb begin
    stat_set                  = 7'h00;
    stat_set[IRQ_TEACH_OK]    = do_learn;
    stat_set[IRQ_FULL]        = do_nospc;
    stat_set[IRQ_WIN_CLOSED]  = win_close;
    stat_set[IRQ_RESYNC]      = do_resync;
    stat_set[IRQ_REPLAY]      = dec_data && found_r && !fresh;
    stat_set[IRQ_PKT_ERR]     = pkt_err;
    stat_set[IRQ_SEND_REFUSE] = cmd_send && !send_ok;
  end

  // Registers; write-one-to-clear never hides a same-cycle event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r      <= 7'h00;
      mask_r      <= IRQ_MASK_RST;
      out_id_r    <= 32'h0000_0000;
      out_valid_r <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~((apb_wr && hit_stat) ? pwdata[6:0] : 7'h00))
                | stat_set;
      if (apb_wr && hit_mask) begin
        mask_r <= pwdata[6:0];
      end
      if (apb_wr && hit_oid) begin
        out_id_r <= pwdata;
      end
      if (apb_wr && hit_octl) begin
        out_valid_r <= pwdata[0];
      end
    end
  end
endmodule

// ---- logic/stc_pkg.sv ----
// Shared constants, carriers and helpers of the secure teach-in controller
package stc_pkg;
  // ==========================================================================
  // Host packet framing
  localparam logic [7:0]  SYNC_BYTE       = 8'h55;
  localparam logic [7:0]  PT_EVENT        = 8'h04;
  localparam logic [7:0]  PT_COMMON       = 8'h05;
  localparam logic [7:0]  CMD_SEND_TEACH  = 8'h20;
  localparam logic [7:0]  CMD_TEACH_WIN   = 8'h17;
  localparam logic [15:0] SEND_TEACH_DLEN = 16'h0005;
  localparam logic [15:0] TEACH_WIN_DLEN  = 16'h0006;
  localparam logic [7:0]  WIN_STOP        = 8'h00;
  localparam logic [7:0]  WIN_START       = 8'h01;
  localparam logic [7:0]  CH_ABS_MAX      = 8'hfd;
  localparam logic [7:0]  CH_PREV         = 8'hfe;
  localparam logic [7:0]  CH_NEXT         = 8'hff;
  // ==========================================================================
  // Event packets
  localparam logic [7:0]  EVT_WIN_CLOSED  = 8'h09;
  localparam logic [7:0]  EVT_SECURE_LINK = 8'h1c; // Arbitrary event code
  localparam logic [7:0]  CAUSE_NO_SPACE  = 8'h00;
  localparam logic [7:0]  CAUSE_TEACH_OK  = 8'h01;
  localparam logic [7:0]  CAUSE_RESYNC    = 8'h02;
  localparam logic [7:0]  WIN_EVT_DLEN    = 8'h01;
  localparam logic [7:0]  SEC_EVT_DLEN    = 8'h06;
  // ==========================================================================
  // Link table and timing
  localparam int          TABLE_DEPTH     = 32;
  localparam logic [31:0] DEFAULT_TO_MS   = 32'd60000;
  localparam int          MS_IN_NS        = 1000000;
  localparam int          CLK_PERIOD_NS   = 4;
  localparam int          CYC_PER_MS      = MS_IN_NS / CLK_PERIOD_NS;
  // ==========================================================================
  // APB register map and interrupt bits
  localparam logic [11:0] OFS_IRQ_STAT    = 12'h000;
  localparam logic [11:0] OFS_IRQ_MASK    = 12'h004;
  localparam logic [11:0] OFS_STATUS      = 12'h008;
  localparam logic [11:0] OFS_OUT_ID      = 12'h00c;
  localparam logic [11:0] OFS_OUT_CTRL    = 12'h010;
  localparam logic [6:0]  IRQ_MASK_RST    = 7'h00;
  localparam logic [7:0]  CHAN_RST        = 8'h00;
  localparam int          IRQ_TEACH_OK    = 0;
  localparam int          IRQ_FULL        = 1;
  localparam int          IRQ_WIN_CLOSED  = 2;
  localparam int          IRQ_RESYNC      = 3;
  localparam int          IRQ_REPLAY      = 4;
  localparam int          IRQ_PKT_ERR     = 5;
  localparam int          IRQ_SEND_REFUSE = 6;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [31:0]  id;
    logic [127:0] key;
    logic [7:0]   security_level_format;
    logic [7:0]   info;
    logic [31:0]  rolling_counter;
  } link_entry_s;
  typedef struct packed {
    logic        teach;
    link_entry_s ent;
  } radio_tlg_s;
  typedef struct packed {
    logic [7:0]      ptype;
    logic [15:0]     dlen;
    logic [7:0]      olen;
    logic [7:0][7:0] body;
  } host_pkt_s;
  // CRC-8, polynomial x^8+x^2+x+1, one byte at a time
  function automatic logic [7:0] crc8_step(input logic [7:0] crc,
                                           input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    return c;
  endfunction
endpackage

// ---- verif/host_sink.sv ----
// Host-side sink of event bytes that stalls every other cycle
module host_sink (
  // Clock, reset and event bytes
  input  wire logic       pclk, presetn, host_tx_valid,
  input  wire logic [7:0] host_tx_data,
  output logic            host_tx_ready,
  // Count and last of the bytes taken
  output int              n_bytes,
  output logic      [7:0] last_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // Toggling ready makes the device hold each byte across a stall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_tx_ready <= 1'b0;
      n_bytes <= 0;
    end else begin
      host_tx_ready <= !host_tx_ready;
      if (host_tx_valid && host_tx_ready) begin
        n_bytes <= n_bytes + 1;
        last_byte <= host_tx_data;
      end
    end
  end
endmodule

// ---- verif/secure_teach_in_control_test.sv ----
// Command, telegram and event test of the secure teach-in controller
module secure_teach_in_control_test import stc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, send_teach_id, r, sq;
  logic pready, pslverr, host_rx_valid = 0, tlg_valid = 0, tlg_ready, e;
  logic [7:0] host_rx_data = '0, host_tx_data, send_teach_info, radio_chan;
  logic host_tx_valid, host_tx_ready, plain_fwd, secure_accept, replay_drop;
  logic send_teach_req, send_teach_info_en, teach_window_active, irq;
  logic [7:0] last_byte;
  logic [2:0] vs;
  radio_tlg_s tlg = '0;
  int n_bytes, fail_count = 0, n_checks = 0;
  always #2 pclk = ~pclk;
  secure_teach_in_control #(.CYC_PER_MS_P(10)) dut_u (.*);
  host_sink sink_u (.*);
  // Hold one-cycle pulses; a new telegram clears
  always @(posedge pclk) begin
    if (tlg_valid && tlg_ready)
      vs <= '0;
    else if (plain_fwd | secure_accept | replay_drop)
      vs <= {plain_fwd, secure_accept, replay_drop};
    if (send_teach_req)
      sq <= send_teach_id;
  end
  task chk(input string s, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", s, exp, got);
    end
  endtask
  task stop_test;
    if (fail_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [7:0] cr(logic [7:0] c, logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    return c;
  endfunction
  // One APB transfer; an idle edge follows so calls may chain
  task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // Frame one host command packet
  task snd(input logic [7:0] q[$], input int o);
    logic [7:0] h[$];
    logic [7:0] c;
    h = {SYNC_BYTE, 8'h00, 8'(q.size() - o), 8'(o), PT_COMMON};
    c = 0;
    for (int i = 1; i < 5; i++)
      c = cr(c, h[i]);
    h.push_back(c);
    c = 0;
    foreach (q[i]) c = cr(c, q[i]);
    h = {h, q, c};
    foreach (h[i]) begin
      host_rx_valid <= 1;
      host_rx_data <= h[i];
      @(posedge pclk);
    end
    host_rx_valid <= 0;
    @(posedge pclk);
  endtask
  task tg(input logic t, input logic [31:0] id, rl, input logic [2:0] x);
    tlg_valid <= 1;
    tlg.teach <= t;
    tlg.ent.id <= id;
    tlg.ent.rolling_counter <= rl;
    do @(posedge pclk); while (tlg_ready !== 1'b1);
    tlg_valid <= 0;
    repeat (70) @(posedge pclk);
    chk("verdict", 32'(vs), 32'(x));
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    tlg.ent.key <= {4{32'h0badf00d}};
    ap(0, OFS_IRQ_MASK, 0);
    chk("mask", r, 32'(IRQ_MASK_RST));
    ap(0, 12'h100, 0);
    chk("unmapped", {r[30:0], e}, 32'h1);
    ap(1, OFS_IRQ_MASK, 32'h7f);
    snd('{CMD_TEACH_WIN, WIN_START, 0, 0, 0, 8'h40, 8'h05}, 1);
    repeat (2) @(posedge pclk);
    chk("window", 32'({teach_window_active, radio_chan}), 32'h105);
    tg(1, 32'ha1, 5, 3'b000);
    tg(0, 32'ha1, 6, 3'b010);
    tg(0, 32'ha1, 6, 3'b001);
    tg(0, 32'hb2, 1, 3'b100);
    repeat (700) @(posedge pclk);
    chk("closed", 32'(teach_window_active), 0);
    chk("evt bytes", n_bytes, 21);
    chk("evt tail", 32'(last_byte), 32'(cr(0, EVT_WIN_CLOSED)));
    ap(0, OFS_IRQ_STAT, 0);
    chk("stat", r, 32'h15);
    chk("irq", 32'(irq), 1);
    ap(1, OFS_IRQ_STAT, 32'h7f);
    chk("irq clr", 32'(irq), 0);
    ap(1, OFS_OUT_ID, 32'hc3);
    ap(1, OFS_OUT_CTRL, 1);
    snd('{CMD_SEND_TEACH, 0, 0, 0, 8'hc3, 8'h07}, 1);
    repeat (2) @(posedge pclk);
    chk("teach id", sq, 32'hc3);
    chk("info", 32'({send_teach_info_en, send_teach_info}), 32'h107);
    snd('{CMD_SEND_TEACH, 0, 0, 0, 8'hc4, 8'h07}, 1);
    ap(0, OFS_IRQ_STAT, 0);
    chk("refused", r, 32'h40);
    tg(1, 32'ha1, 9, 3'b000);
    tg(0, 32'ha1, 7, 3'b001);
    tg(1, 32'hd4, 1, 3'b000);
    tg(0, 32'hd4, 2, 3'b100);
    snd('{CMD_TEACH_WIN, WIN_START, 0, 0, 0, 0, CH_PREV}, 1);
    snd('{CMD_TEACH_WIN, WIN_STOP, 0, 0, 0, 0}, 0);
    repeat (20) @(posedge pclk);
    chk("stop", 32'({teach_window_active, radio_chan}), 4);
    chk("evt total", n_bytes, 42);
    stop_test;
  end
  // Watchdog sized well beyond the expected run
  initial begin
    #40000;
    fail_count++;
    stop_test;
  end
endmodule

// ---- verif/stc_chk_assertions.sv ----
// Port assertions of the secure teach-in controller
module stc_chk import stc_pkg::*; (
  // Clock, bus, host link, radio and status
  input wire logic pclk, presetn, psel, penable, pready, pslverr,
  input wire logic host_tx_valid, host_tx_ready, tlg_valid, tlg_ready,
  input wire logic [7:0] host_tx_data,
  input radio_tlg_s tlg,
  input wire logic plain_fwd, secure_accept, replay_drop,
  input wire logic send_teach_req, teach_window_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Verdict pulses grouped so one telegram maps to one outcome
  wire logic [2:0] vd = {plain_fwd, secure_accept, replay_drop};
  AST_READY: assert property (pready)
    else $error("pready low");
  AST_ERR: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  AST_REQ: assert property (send_teach_req |=> !send_teach_req)
    else $error("teach request too long");
  AST_ONE: assert property ($onehot0(vd))
    else $error("two verdicts");
  AST_VERD: assert property (tlg_valid && tlg_ready && !tlg.teach
    |-> ##[1:70] vd != 3'b000)
    else $error("no verdict");
  AST_BUSY: assert property (tlg_valid && tlg_ready |=> !tlg_ready)
    else $error("ready while busy");
  AST_HOLD: assert property (host_tx_valid && !host_tx_ready
    |=> host_tx_valid && $stable(host_tx_data))
    else $error("event byte dropped");
  AST_CLOSE: assert property ($fell(teach_window_active)
    |-> ##[1:100] host_tx_valid && host_tx_data == SYNC_BYTE)
    else $error("no close event");
endmodule
bind secure_teach_in_control stc_chk chk_u (.*);
